// ### inc/pb_power_params.svh
`ifndef PB_POWER_PARAMS_SVH
`define PB_POWER_PARAMS_SVH
// clock rate and documented times
`define CLK_HZ 40000000
`define TURN_ON_DEBOUNCE_MS 32
`define TURN_OFF_DEBOUNCE_MS 32
`define MIN_PULSE_MS 32
`define FIXED_PD_MS 64
`define BLANKING_MS 512
`define RESET_HOLD_MS 200
`define MS_TO_CYC(ms) ((`CLK_HZ / 1000) * (ms))
// cycles derived from the times
`define TURN_ON_DEBOUNCE_CYC `MS_TO_CYC(`TURN_ON_DEBOUNCE_MS)
`define TURN_OFF_DEBOUNCE_CYC `MS_TO_CYC(`TURN_OFF_DEBOUNCE_MS)
`define MIN_PULSE_CYC `MS_TO_CYC(`MIN_PULSE_MS)
`define FIXED_PD_CYC `MS_TO_CYC(`FIXED_PD_MS)
`define BLANKING_CYC `MS_TO_CYC(`BLANKING_MS)
`define RESET_HOLD_CYC `MS_TO_CYC(`RESET_HOLD_MS)
`define CNT_W 32
`endif

// ### inc/pb_power_pkg.sv
package pb_power_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_BLANK, ST_ON, ST_REQ
  } pwr_state_t;
  typedef enum logic [1:0] {
    OWN_NONE, OWN_BUTTON, OWN_UV
  } owner_t;
  typedef struct packed {
    logic [2:0] pb_sync;
    logic [2:0] uv_sync;
    logic [2:0] kill_sync;
    logic [2:0] pf_sync;
    logic [2:0] vm_sync;
    logic pb_low;
    logic uv_low;
    logic kill_low;
    logic pf_low;
    logic vm_low;
    pwr_state_t state;
    owner_t owner;
    logic [31:0] on_cnt;
    logic [31:0] blank_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] pulse_cnt;
    logic [31:0] rst_cnt;
    logic enable;
    logic req_n;
    logic pf_out_n;
    logic rst_out_n;
  } state_t;
endpackage

// ### core/push_button_power_controller.sv
`timescale 1ns/100ps
`include "pb_power_params.svh"
// How it works
// - enable asserts after button held low for full turn-on debounce
// - blanking starts at enable; kill still low at end drops enable
// - kill level ignored during turn-on blanking
// - button and undervoltage also ignored during blanking
// - after blanking, kill low releases enable
// - press of debounce length raises shutdown request, short press keeps on
// - request stays low at least minimum pulse and while button held
// - owner held low past fixed plus adjustable delay drops enable and releases request
// - adjustable delay is configurable; zero gives fixed delay alone
// - undervoltage low past debounce raises request for minimum pulse
// - undervoltage held for extra delay drops enable without host
// - while off and undervoltage low, button is ignored
// - only the button path turns power on
// - first input low owns power-down; other ignored until done
// - power-fail output follows comparator; only clock enable and reset act on it
// - monitor reset low while under, held for hold time after
// - reset monitor independent of other pins and enable; clock enable freezes it
// - enable polarity is a build option
module push_button_power_controller #(
  parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
  parameter int unsigned TURN_ON_CYC = `TURN_ON_DEBOUNCE_CYC,
  parameter int unsigned TURN_OFF_CYC = `TURN_OFF_DEBOUNCE_CYC,
  parameter int unsigned PULSE_CYC = `MIN_PULSE_CYC,
  parameter int unsigned FIXED_PD_CYC = `FIXED_PD_CYC,
  parameter int unsigned BLANK_CYC = `BLANKING_CYC,
  parameter int unsigned RST_HOLD_CYC = `RESET_HOLD_CYC
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // pins and comparator results
  input wire logic push_button_n,
  input wire logic undervoltage_input,
  input wire logic power_kill_n,
  input wire logic power_fail_input,
  input wire logic voltage_monitor_input,
  // adjustable power-down delay in cycles
  input wire logic [31:0] power_down_timer_setting,
  // outputs
  output logic power_enable,
  output logic shutdown_request_n,
  output logic power_fail_output_n,
  output logic monitor_reset_n
);
  pb_power_pkg::state_t s_reg;
  pb_power_pkg::state_t s_next;
  logic [31:0] pd_total;
  logic owner_low;

  // total forced power-down delay
  assign pd_total = FIXED_PD_CYC + power_down_timer_setting;
  assign owner_low = (s_reg.owner == pb_power_pkg::OWN_BUTTON) ?
                     s_reg.pb_low : s_reg.uv_low;

  always_comb begin
    s_next = s_reg;
    // three-stage sync; change counts when stages 2 and 3 agree
    s_next.pb_sync = {s_reg.pb_sync[1:0], push_button_n};
    s_next.uv_sync = {s_reg.uv_sync[1:0], undervoltage_input};
    s_next.kill_sync = {s_reg.kill_sync[1:0], power_kill_n};
    s_next.pf_sync = {s_reg.pf_sync[1:0], power_fail_input};
    s_next.vm_sync = {s_reg.vm_sync[1:0], voltage_monitor_input};
    if (s_reg.pb_sync[1] == s_reg.pb_sync[2])
      s_next.pb_low = !s_reg.pb_sync[2];
    if (s_reg.uv_sync[1] == s_reg.uv_sync[2])
      s_next.uv_low = !s_reg.uv_sync[2];
    if (s_reg.kill_sync[1] == s_reg.kill_sync[2])
      s_next.kill_low = !s_reg.kill_sync[2];
    if (s_reg.pf_sync[1] == s_reg.pf_sync[2])
      s_next.pf_low = !s_reg.pf_sync[2];
    if (s_reg.vm_sync[1] == s_reg.vm_sync[2])
      s_next.vm_low = !s_reg.vm_sync[2];

    // power-fail pass-through, no other input involved
    s_next.pf_out_n = !s_reg.pf_low;

    // reset monitor with hold time, independent of the rest
    if (s_reg.vm_low) begin
      s_next.rst_out_n = 1'b0;
      s_next.rst_cnt = '0;
    end else if (!s_reg.rst_out_n) begin
      if (s_reg.rst_cnt >= RST_HOLD_CYC - 1)
        s_next.rst_out_n = 1'b1;
      else
        s_next.rst_cnt = s_reg.rst_cnt + 32'h1;
    end

    // minimum request pulse timer
    if (!s_reg.req_n && s_reg.pulse_cnt < PULSE_CYC)
      s_next.pulse_cnt = s_reg.pulse_cnt + 32'h1;

    unique case (s_reg.state)
      pb_power_pkg::ST_OFF: begin
        // undervoltage locks out button; only button turns on
        if (s_reg.pb_low && !s_reg.uv_low) begin
          if (s_reg.on_cnt >= TURN_ON_CYC - 1) begin
            s_next.state = pb_power_pkg::ST_BLANK;
            s_next.enable = 1'b1;
            s_next.on_cnt = '0;
            s_next.blank_cnt = '0;
          end else
            s_next.on_cnt = s_reg.on_cnt + 32'h1;
        end else
          s_next.on_cnt = '0; // interruption restarts debounce
      end
      pb_power_pkg::ST_BLANK: begin
        // button, undervoltage not looked at here; kill only at the end
        if (s_reg.blank_cnt >= BLANK_CYC - 1) begin
          s_next.blank_cnt = '0;
          if (s_reg.kill_low) begin
            s_next.state = pb_power_pkg::ST_OFF;
            s_next.enable = 1'b0;
          end else
            s_next.state = pb_power_pkg::ST_ON;
        end else
          s_next.blank_cnt = s_reg.blank_cnt + 32'h1;
      end
      pb_power_pkg::ST_ON, pb_power_pkg::ST_REQ: begin
        // pick an owner: first input low wins
        if (s_reg.owner == pb_power_pkg::OWN_NONE) begin
          s_next.hold_cnt = '0;
          if (s_reg.pb_low)
            s_next.owner = pb_power_pkg::OWN_BUTTON;
          else if (s_reg.uv_low)
            s_next.owner = pb_power_pkg::OWN_UV;
        end else if (owner_low) begin
          s_next.hold_cnt = s_reg.hold_cnt + 32'h1;
          // debounce met: raise request
          if (s_reg.hold_cnt == TURN_OFF_CYC - 1 && s_reg.req_n) begin
            s_next.req_n = 1'b0;
            s_next.pulse_cnt = '0;
            s_next.state = pb_power_pkg::ST_REQ;
          end
          // forced power-down by owner held long
          if (s_reg.hold_cnt >= pd_total - 1) begin
            s_next.state = pb_power_pkg::ST_OFF;
            s_next.enable = 1'b0;
            s_next.req_n = 1'b1;
            s_next.owner = pb_power_pkg::OWN_NONE;
          end
        end else begin
          // owner released early: enable stays on
          s_next.owner = pb_power_pkg::OWN_NONE;
          s_next.hold_cnt = '0;
        end
        // release request after minimum width and button let go
        if (!s_reg.req_n && s_reg.pulse_cnt >= PULSE_CYC - 1 &&
            !(s_reg.owner == pb_power_pkg::OWN_BUTTON && s_reg.pb_low))
          s_next.req_n = 1'b1;
        // host kill low drops enable
        if (s_reg.kill_low) begin
          s_next.state = pb_power_pkg::ST_OFF;
          s_next.enable = 1'b0;
          s_next.req_n = 1'b1;
          s_next.owner = pb_power_pkg::OWN_NONE;
          s_next.hold_cnt = '0;
        end
      end
      default: begin
        s_next.state = pb_power_pkg::ST_OFF;
        s_next.enable = 1'b0;
      end
    endcase
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.pb_sync <= 3'h7;
      s_reg.uv_sync <= 3'h7;
      s_reg.kill_sync <= 3'h7;
      s_reg.pf_sync <= 3'h7;
      s_reg.state <= pb_power_pkg::ST_OFF;
      s_reg.owner <= pb_power_pkg::OWN_NONE;
      s_reg.req_n <= 1'b1;
      s_reg.pf_out_n <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops; polarity by build option
  assign power_enable = ENABLE_ACTIVE_HIGH ? s_reg.enable : !s_reg.enable;
  assign shutdown_request_n = s_reg.req_n;
  assign power_fail_output_n = s_reg.pf_out_n;
  assign monitor_reset_n = s_reg.rst_out_n;

  property p_rst_low;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && s_reg.vm_low) |=> !monitor_reset_n;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset not low");

  property p_pf_follow;
    @(posedge ref_clk) disable iff (!reset_n)
      clk_en |=> power_fail_output_n == !$past(s_reg.pf_low);
  endproperty
  a_pf_follow: assert property (p_pf_follow) else $error("pf mismatch");

  property p_lockout;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_reg.state == pb_power_pkg::ST_OFF && s_reg.uv_low)
        |=> s_reg.state == pb_power_pkg::ST_OFF;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout fail");

  property p_blank_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_reg.state == pb_power_pkg::ST_BLANK && s_reg.blank_cnt < BLANK_CYC - 1)
        |=> s_reg.enable;
  endproperty
  a_blank_keep: assert property (p_blank_keep) else $error("blank drop");

  property p_kill_off;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && s_reg.state == pb_power_pkg::ST_ON && s_reg.kill_low)
        |=> !s_reg.enable;
  endproperty
  a_kill_off: assert property (p_kill_off) else $error("kill ignored");

  property p_on_only_button;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(s_reg.enable) |-> $past(s_reg.pb_low);
  endproperty
  a_on_only_button: assert property (p_on_only_button) else $error("bad on");

  property p_req_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (!s_reg.req_n && s_reg.owner == pb_power_pkg::OWN_BUTTON && s_reg.pb_low
       && s_reg.enable && !s_reg.kill_low && s_reg.hold_cnt < pd_total - 1)
        |=> !shutdown_request_n;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req early");

  property p_blank_end;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && s_reg.state == pb_power_pkg::ST_BLANK &&
       s_reg.blank_cnt >= BLANK_CYC - 1 && s_reg.kill_low) |=> !s_reg.enable;
  endproperty
  a_blank_end: assert property (p_blank_end) else $error("no abort");

  // owner still low inside a live on state, host not killing
  sequence s_owner_held;
    clk_en && !s_reg.kill_low && s_reg.owner != pb_power_pkg::OWN_NONE &&
    (s_reg.state == pb_power_pkg::ST_ON ||
     s_reg.state == pb_power_pkg::ST_REQ) && owner_low;
  endsequence

  // forced release must drop both outputs at once
  sequence s_forced;
    clk_en && (s_reg.state == pb_power_pkg::ST_ON ||
     s_reg.state == pb_power_pkg::ST_REQ) &&
    s_reg.owner != pb_power_pkg::OWN_NONE && owner_low &&
    s_reg.hold_cnt >= pd_total - 1;
  endsequence

  property p_force;
    @(posedge ref_clk) disable iff (!reset_n)
      s_forced |=> !s_reg.enable && shutdown_request_n;
  endproperty
  a_force: assert property (p_force) else $error("no force off");

  property p_debounce_req;
    @(posedge ref_clk) disable iff (!reset_n)
      s_owner_held ##0 (s_reg.hold_cnt == TURN_OFF_CYC - 1 && s_reg.req_n &&
        s_reg.hold_cnt < pd_total - 1) |=> !shutdown_request_n;
  endproperty
  a_debounce_req: assert property (p_debounce_req) else $error("no req");

  property p_owner_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      s_owner_held ##0 (s_reg.owner == pb_power_pkg::OWN_BUTTON &&
        s_reg.hold_cnt < pd_total - 1)
        |=> s_reg.owner == pb_power_pkg::OWN_BUTTON;
  endproperty
  a_owner_keep: assert property (p_owner_keep) else $error("owner lost");

  // short press: owner let go before forced release keeps power on
  property p_short_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !s_reg.kill_low && s_reg.state == pb_power_pkg::ST_ON &&
       s_reg.owner == pb_power_pkg::OWN_BUTTON && !s_reg.pb_low)
        |=> s_reg.enable;
  endproperty
  a_short_keep: assert property (p_short_keep) else $error("short off");

  property p_on_debounce;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(s_reg.enable) |-> $past(s_reg.on_cnt) == TURN_ON_CYC - 1;
  endproperty
  a_on_debounce: assert property (p_on_debounce) else $error("early on");

  // nothing but the timer moves the blanking state
  property p_blank_ignore;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && s_reg.state == pb_power_pkg::ST_BLANK &&
       s_reg.blank_cnt < BLANK_CYC - 1)
        |=> s_reg.state == pb_power_pkg::ST_BLANK &&
            s_reg.owner == pb_power_pkg::OWN_NONE;
  endproperty
  a_blank_ignore: assert property (p_blank_ignore) else $error("blank left");

  property p_mon_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !s_reg.vm_low && !s_reg.rst_out_n &&
       s_reg.rst_cnt < RST_HOLD_CYC - 1) |=> !monitor_reset_n;
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("hold short");

  // a level only counts once stages two and three agree
  property p_sync_agree;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && s_reg.pb_sync[1] != s_reg.pb_sync[2])
        |=> $stable(s_reg.pb_low);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync early");
endmodule

// ### tb/host_model.sv
`timescale 1ns/100ps
// host side of the kill handshake; mode 0 silent, 1 obeys, 2 deaf
module host_model (
  // clock, observed outputs and host mode
  input wire logic ref_clk,
  input wire logic power_enable,
  input wire logic shutdown_request_n,
  input wire logic [1:0] mode,
  // handshake back to the controller
  output logic power_kill_n
);
  int wait_cnt = 0;
  initial power_kill_n = 1'b0;
  // housekeeping takes a few cycles before kill goes low
  always @(negedge ref_clk) begin
    if (power_enable !== 1'b1 || mode == 2'h0) begin
      power_kill_n <= 1'b0; // silent host leaves kill low
      wait_cnt <= 0;
    end else if (mode == 2'h1 && shutdown_request_n === 1'b0) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= 5) power_kill_n <= 1'b0;
    end else begin
      power_kill_n <= 1'b1;
    end
  end
endmodule

// ### tb/push_button_power_controller_bench.sv
`timescale 1ns/100ps
module push_button_power_controller_bench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic push_button_n = 1'b1;
  logic uv = 1'b1;
  logic pf = 1'b1;
  logic vm = 1'b1;
  logic [31:0] setting = 32'h0;
  logic [1:0] mode = 2'h1;
  logic clk_en = 1'b1;
  logic kill_n, en, req_n, pfo_n, rst_n;
  int n_fail = 0;
  int checked = 0;
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  // shortened counts keep the run small
  push_button_power_controller #(.TURN_ON_CYC(20), .TURN_OFF_CYC(20),
    .PULSE_CYC(20), .FIXED_PD_CYC(40), .BLANK_CYC(60),
    .RST_HOLD_CYC(30)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .clk_en(clk_en), .push_button_n(push_button_n),
    .undervoltage_input(uv), .power_kill_n(kill_n),
    .power_fail_input(pf), .voltage_monitor_input(vm),
    .power_down_timer_setting(setting), .power_enable(en),
    .shutdown_request_n(req_n), .power_fail_output_n(pfo_n),
    .monitor_reset_n(rst_n));
  host_model host (.ref_clk(ref_clk), .power_enable(en),
    .shutdown_request_n(req_n), .mode(mode), .power_kill_n(kill_n));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task press(input int n);
    push_button_n = 1'b0;
    cyc(n);
    push_button_n = 1'b1;
  endtask
  task stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // turn on and sit past blanking with the given host behaviour
  task power_on(input logic [1:0] m);
    mode = m;
    press(30);
    chk(en, 1'b1);
    cyc(70);
    chk(en, 1'b1);
  endtask
  // a short press must not turn on; a long one does
  task t_turn_on;
    press(10);
    cyc(30);
    chk(en, 1'b0);
    power_on(2'h2);
  endtask
  // host that never raises kill loses power at blanking end
  task t_abort;
    mode = 2'h0;
    press(30);
    cyc(20);
    chk(en, 1'b1); // kill low ignored inside blanking
    cyc(45);
    chk(en, 1'b0);
    cyc(20);
  endtask
  // interrupt press keeps power, then an obeying host kills it
  task t_request;
    power_on(2'h2);
    press(30);
    chk(req_n, 1'b0);
    cyc(10);
    chk(req_n, 1'b0); // minimum pulse after release
    chk(en, 1'b1);
    cyc(40);
    chk(req_n, 1'b1);
    mode = 2'h1;
    press(30);
    cyc(15);
    chk(en, 1'b0);
    chk(req_n, 1'b1);
    cyc(20);
  endtask
  // held button forces power off after fixed plus adjustable delay
  task t_forced;
    setting = 32'ha;
    power_on(2'h2);
    push_button_n = 1'b0;
    cyc(45);
    chk(en, 1'b1); // extra delay still running
    chk(req_n, 1'b0); // held button keeps request low
    cyc(15);
    push_button_n = 1'b1;
    chk(en, 1'b0);
    chk(req_n, 1'b1);
    setting = 32'h0;
    cyc(20);
  endtask
  // undervoltage raises request, forces off, then locks out the button
  task t_uv;
    power_on(2'h2);
    uv = 1'b0;
    cyc(30);
    chk(req_n, 1'b0);
    chk(en, 1'b1);
    cyc(20);
    chk(en, 1'b0);
    press(40);
    cyc(5);
    chk(en, 1'b0);
    uv = 1'b1;
    cyc(40);
  endtask
  // power-fail pass-through and reset hold, with power off
  task t_monitors;
    clk_en = 1'b0;
    pf = 1'b0;
    cyc(6);
    chk(pfo_n, 1'b1); // frozen clock enable holds all state
    clk_en = 1'b1;
    cyc(6);
    chk(pfo_n, 1'b0);
    pf = 1'b1;
    cyc(6);
    chk(pfo_n, 1'b1);
    vm = 1'b0;
    cyc(6);
    chk(rst_n, 1'b0);
    vm = 1'b1;
    cyc(20);
    chk(rst_n, 1'b0); // hold time still running
    cyc(20);
    chk(rst_n, 1'b1);
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    cyc(10);
    reset_n = 1'b1;
    cyc(50);
    t_turn_on();
    press(30);
    cyc(30);
    t_abort();
    t_request();
    t_forced();
    t_uv();
    t_monitors();
    stop_test();
  end
endmodule
